// >>> rtl/mq_shift_right_unit.sv
`timescale 1ns/10ps

// Overview of operation
// - extended opcodes 729, 696, 760 pick reg merge, imm mask, imm merge
// - bits 6-10 source, 11-15 target, 16-20 amount register or immediate
// - register forms take count from amount bits 27-31; rotate left 32-n
// - mask is n zeros then 32-n ones for every variant
// - reg merge: rotated word to aux, mask merge with old aux to target
// - imm mask: immediate count, rotated to aux, rotated and mask to target
// - imm merge: immediate count, merge with old aux, rotated to aux
// - algebraic form updates carry whatever the record bit
// - record bit 1 updates field 0 sign and summary flags; 0 leaves them
// - other three forms leave exception register and carry untouched
// - extended opcode 921 picks the algebraic form
// - algebraic: rotated to aux, merge with sign word to target
// - carry is or of rotated and not mask, anded with source sign
module mq_shift_right_unit
    import mq_shift_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic [3:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    output logic [31:0]      readdata,
    output logic             waitrequest,
    output logic [31:0]      target_gpr,
    output logic [4:0]       target_index,
    output logic             target_write,
    output logic [3:0]       cr0_field,
    output logic             shift_out_flag
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {idle, answer} bus_state_t;

    bus_state_t  state;
    logic [31:0] source_word;
    logic [31:0] amount_word;
    logic [31:0] multiplier_quotient_register;
    logic        summary_overflow;
    logic        illegal_op;
    logic        last_wrote;        // level copy of the target strobe
    flag_set_t   flags;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    logic        wr_instr;
    logic        wr_source;
    logic        wr_amount;
    logic        wr_aux;
    logic        wr_flags;
    logic        is_family;
    logic [9:0]  xop;
    logic        record_bit;
    logic [4:0]  immediate_amount;
    logic [4:0]  target_sel;
    logic [4:0]  count;
    op_kind_t    kind;
    logic        family_hit;
    logic        register_form;
    logic [31:0] next_result;
    logic [31:0] next_rotated;
    logic        next_carry;
    logic [3:0]  next_cr0;
    logic [31:0] next_readdata;
    logic        take;

    // a request is answered one cycle after it is seen
    assign take      = (state == idle) && (read || write);
    assign wr_instr  = take && write && (address == addr_instr);
    assign wr_source = take && write && (address == addr_source);
    assign wr_amount = take && write && (address == addr_amount);
    assign wr_aux    = take && write && (address == addr_aux);
    assign wr_flags  = take && write && (address == addr_flags);

    // instruction fields
    assign is_family = (writedata[31:primary_lsb] == primary_opcode);
    assign xop       = writedata[xop_lsb +: 10];
    assign record_bit = writedata[record_pos];
    assign immediate_amount = writedata[amount_lsb +: 5];
    assign target_sel = writedata[target_lsb +: 5];

    // extended opcode picks the variant
    assign kind = !is_family ? op_none :
                  (xop == xop_merge_reg) ? op_merge_reg :
                  (xop == xop_mask_imm)  ? op_mask_imm :
                  (xop == xop_merge_imm) ? op_merge_imm :
                  (xop == xop_algebraic) ? op_algebraic : op_none;
    assign family_hit = (kind != op_none);
    assign register_form = (kind == op_merge_reg) ||
                           (kind == op_algebraic);
    // register forms read the low five bits of the amount word
    assign count = register_form ? amount_word[count_lsb +: 5]
                                 : immediate_amount;

    // datapath: rotate, mask, merge, flags
    mq_shift_core u_core (
        .kind       (kind),
        .source_gpr (source_word),
        .count      (count),
        .aux_in     (multiplier_quotient_register),
        .summary_in (summary_overflow),
        .result     (next_result),
        .rotated    (next_rotated),
        .carry      (next_carry),
        .cr0        (next_cr0)
    );

    // read mux
    assign next_readdata =
        (address == addr_instr)  ? reset_word :
        (address == addr_source) ? source_word :
        (address == addr_amount) ? amount_word :
        (address == addr_aux)    ? multiplier_quotient_register :
        (address == addr_result) ? target_gpr :
        (address == addr_flags)  ?
            {22'h000000, illegal_op, last_wrote, 2'b00,
             summary_overflow, flags.carry, flags.cr0} :
        unmapped_rd;

    // ------------------------------------------------------------
    // bus handshake
    // ------------------------------------------------------------
    // waitrequest high at rest so the master waits for the answer cycle
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state       <= idle;
            waitrequest <= 1'b1;
            readdata    <= reset_word;
        end else begin
            case (state)
                idle: begin
                    if (take) begin
                        state       <= answer;
                        waitrequest <= 1'b0;
                        readdata    <= next_readdata;
                    end
                end
                answer: begin
                    state       <= idle;
                    waitrequest <= 1'b1;
                end
                default: begin
                    state       <= idle;
                    waitrequest <= 1'b1;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // operand registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            source_word <= reset_word;
            amount_word <= reset_word;
        end else begin
            if (wr_source) begin
                source_word <= writedata;
            end
            if (wr_amount) begin
                amount_word <= writedata;
            end
        end
    end

    // ------------------------------------------------------------
    // auxiliary register: every family member stores the rotated word
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            multiplier_quotient_register <= reset_word;
        end else if (wr_instr && family_hit) begin
            // old contents feed the merge in the same cycle
            multiplier_quotient_register <= next_rotated;
        end else if (wr_aux) begin
            multiplier_quotient_register <= writedata;
        end
    end

    // ------------------------------------------------------------
    // target result
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            target_gpr   <= reset_word;
            target_index <= 5'h00;
            target_write <= 1'b0;
            illegal_op   <= 1'b0;
            last_wrote   <= 1'b0;
        end else if (wr_instr) begin
            target_write <= family_hit;
            illegal_op   <= ~family_hit;
            // the strobe is gone before software can read, keep a level
            last_wrote   <= family_hit;
            if (family_hit) begin
                target_gpr   <= next_result;
                target_index <= target_sel;
            end
        end else begin
            target_write <= 1'b0;               // one-cycle strobe
        end
    end

    // ------------------------------------------------------------
    // condition field 0 and carry
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            flags            <= '0;
            summary_overflow <= 1'b0;
        end else begin
            if (wr_instr && family_hit && record_bit) begin
                flags.cr0 <= next_cr0;
            end
            // only the algebraic form touches carry
            if (wr_instr && kind == op_algebraic) begin
                flags.carry <= next_carry;
            end else if (wr_flags) begin
                flags.carry <= writedata[flag_carry_pos];
            end
            if (wr_flags) begin
                summary_overflow <= writedata[flag_xso_pos];
            end
        end
    end

    // outputs straight from flip-flops
    assign cr0_field      = flags.cr0;
    assign shift_out_flag = flags.carry;
endmodule // mq_shift_right_unit

// >>> rtl/mq_shift_pkg.sv
package mq_shift_pkg;

    // ------------------------------------------------------------
    // instruction fields, big-endian bit numbering (bit 0 = msb)
    // ------------------------------------------------------------
    localparam logic [5:0] primary_opcode = 6'h1f;   // 31
    localparam logic [9:0] xop_merge_reg  = 10'h2d9; // 729
    localparam logic [9:0] xop_mask_imm   = 10'h2b8; // 696
    localparam logic [9:0] xop_merge_imm  = 10'h2f8; // 760
    localparam logic [9:0] xop_algebraic  = 10'h399; // 921

    // little-endian positions in the 32-bit instruction word
    localparam int primary_lsb   = 26;  // bits 0-5
    localparam int source_lsb    = 21;  // bits 6-10
    localparam int target_lsb    = 16;  // bits 11-15
    localparam int amount_lsb    = 11;  // bits 16-20
    localparam int xop_lsb       = 1;   // bits 21-30
    localparam int record_pos    = 0;   // bit 31
    localparam int count_lsb     = 0;   // amount register bits 27-31

    // ------------------------------------------------------------
    // register bus map (word indices, one 32-bit word each)
    // ------------------------------------------------------------
    localparam logic [3:0] addr_instr   = 4'h0; // instruction, starts op
    localparam logic [3:0] addr_source  = 4'h1; // source operand word
    localparam logic [3:0] addr_amount  = 4'h2; // amount operand word
    localparam logic [3:0] addr_aux     = 4'h3; // auxiliary register
    localparam logic [3:0] addr_result  = 4'h4; // target result (ro)
    localparam logic [3:0] addr_flags   = 4'h5; // cr0, carry, so, status
    localparam logic [31:0] unmapped_rd = 32'hdead_beef;

    // flags register field positions
    localparam int flag_sum_pos   = 0;  // cr0 summary overflow
    localparam int flag_zero_pos  = 1;
    localparam int flag_above_pos = 2;
    localparam int flag_below_pos = 3;
    localparam int flag_carry_pos = 4;
    localparam int flag_xso_pos   = 5;  // exception summary overflow, rw
    localparam int flag_wen_pos   = 8;  // last op wrote target
    localparam int flag_ill_pos   = 9;  // last op was not of the family

    localparam logic [31:0] reset_word = 32'h0000_0000;

    typedef enum logic [2:0] {
        op_none,
        op_merge_reg,
        op_mask_imm,
        op_merge_imm,
        op_algebraic
    } op_kind_t;

    typedef struct packed {
        logic [3:0] cr0;       // below above zero summary
        logic       carry;
    } flag_set_t;

endpackage

// >>> rtl/mq_shift_core.sv
`timescale 1ns/10ps

// ----------------------------------------------------------------
// combinational rotate, mask and merge
// ----------------------------------------------------------------
module mq_shift_core
    import mq_shift_pkg::*;
(
    input  wire op_kind_t    kind,
    input  wire logic [31:0] source_gpr,
    input  wire logic [4:0]  count,
    input  wire logic [31:0] aux_in,
    input  wire logic        summary_in,
    output logic [31:0]      result,
    output logic [31:0]      rotated,
    output logic             carry,
    output logic [3:0]       cr0
);
    logic [63:0] doubled;
    logic [31:0] mask;
    logic [31:0] other;
    logic [31:0] sign_word;

    // rotate left by 32-n is a right rotate by n
    assign doubled   = {source_gpr, source_gpr} >> count;
    assign rotated   = doubled[31:0];
    assign mask      = 32'hffff_ffff >> count;
    assign sign_word = {32{source_gpr[31]}};
    assign other     = (kind == op_algebraic) ? sign_word :
                       (kind == op_mask_imm) ? 32'h0000_0000 : aux_in;
    // mask ones take the rotated word, zeros the other operand
    assign result = (rotated & mask) | (other & ~mask);
    // carry: shifted-out bits of a negative source
    assign carry  = (|(rotated & ~mask)) & source_gpr[31];
    // below, above, zero, summary from a signed compare with zero
    assign cr0 = {result[31], ~result[31] & (|result),
                  ~(|result), summary_in};
endmodule // mq_shift_core

// >>> bench/gpr_file_model.sv
`timescale 1ns/10ps

// ------------------------------------------------------------
// register file on the far side of the target port
// ------------------------------------------------------------
module gpr_file_model (
    input  wire logic        clk,
    input  wire logic        target_write,
    input  wire logic [4:0]  target_index,
    input  wire logic [31:0] target_gpr,
    output logic [31:0]      last_val,
    output logic [4:0]       last_idx,
    output int               wr_cnt
);
    // counts every strobed cycle, so a stretched pulse shows up twice
    initial wr_cnt = 0;
    always @(posedge clk) begin
        if (target_write === 1'b1) begin
            last_val <= target_gpr;
            last_idx <= target_index;
            wr_cnt <= wr_cnt + 1;
        end
    end
endmodule // gpr_file_model

// >>> bench/mq_shift_checker.sv
`timescale 1ns/10ps

// ------------------------------------------------------------
// port checker
// ------------------------------------------------------------
module mq_shift_checker
    import mq_shift_pkg::*;
(
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic [3:0]  address,
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] writedata,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    input wire logic [31:0] target_gpr,
    input wire logic [4:0]  target_index,
    input wire logic        target_write,
    input wire logic [3:0]  cr0_field,
    input wire logic        shift_out_flag
);
    // instruction writes decoded from the bus
    wire       take  = write && waitrequest && address == addr_instr;
    wire [9:0] xop   = writedata[10:1];
    wire       fam31 = take && writedata[31:26] == primary_opcode;
    wire       alg   = fam31 && xop == xop_algebraic;
    wire       imm_m = fam31 && xop == xop_mask_imm;
    wire       plain = fam31 && (xop == xop_merge_reg || imm_m
                       || xop == xop_merge_imm);
    logic      src_sign;

    // shadow of the source sign, the unit keeps it out of sight
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn)
            src_sign <= 1'b0;
        else if (write && waitrequest && address == addr_source)
            src_sign <= writedata[31];
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    AST_INDEX: assert property (
        alg || plain |=> target_write && target_index == $past(writedata[20:16]))
        else $error("target index or strobe wrong");
    AST_NONFAM: assert property (
        take && !(alg || plain) |=> !target_write)
        else $error("foreign instruction wrote target");
    AST_MASK_IMM: assert property (
        imm_m |=> (target_gpr & ~(32'hffff_ffff >> $past(writedata[15:11])))
        == 32'h0) else $error("masked result has high ones");
    AST_CR0_SIGN: assert property (
        (alg || plain) && writedata[0] |=> cr0_field[3:1] == {target_gpr[31],
        !target_gpr[31] && |target_gpr, ~|target_gpr})
        else $error("field 0 does not match result");
    AST_CR0_HOLD: assert property (
        take && !writedata[0] |=> $stable(cr0_field))
        else $error("field 0 changed without record bit");
    AST_CARRY_HOLD: assert property (
        plain |=> $stable(shift_out_flag))
        else $error("carry changed by non algebraic op");
    AST_CARRY_POS: assert property (
        alg && !src_sign |=> !shift_out_flag)
        else $error("carry set for positive source");
    AST_SIGN_TOP: assert property (
        alg |=> target_gpr[31] == src_sign)
        else $error("algebraic result lost the sign");
endmodule // mq_shift_checker

bind mq_shift_right_unit mq_shift_checker i_chk (.clk(clk), .resetn(resetn),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .target_gpr(target_gpr),
    .target_index(target_index), .target_write(target_write),
    .cr0_field(cr0_field), .shift_out_flag(shift_out_flag));

// >>> bench/mq_shift_right_unit_test.sv
`timescale 1ns/10ps

`define CHK(g, e) begin checked++; if ((g) !== (e)) begin error_cnt++; \
    $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end

module mq_shift_right_unit_test
    import mq_shift_pkg::*;
;
    logic        clk, resetn, read, write, waitrequest, target_write;
    logic        shift_out_flag;
    logic [3:0]  address, cr0_field;
    logic [4:0]  target_index, last_idx;
    logic [31:0] writedata, readdata, target_gpr, last_val;
    logic [9:0]  xops [4] = '{xop_merge_reg, xop_mask_imm, xop_merge_imm,
                              xop_algebraic};
    int          wr_cnt, error_cnt = 0, checked = 0, cyc = 0;

    mq_shift_right_unit i_dut (.clk(clk), .resetn(resetn), .address(address),
        .read(read), .write(write), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest),
        .target_gpr(target_gpr), .target_index(target_index),
        .target_write(target_write), .cr0_field(cr0_field),
        .shift_out_flag(shift_out_flag));
    gpr_file_model i_gpr (.clk(clk), .target_write(target_write),
        .target_index(target_index), .target_gpr(target_gpr),
        .last_val(last_val), .last_idx(last_idx), .wr_cnt(wr_cnt));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // expected {carry, target, rotated}; rotate left 32-n = right n
    function automatic logic [64:0] model(input int k,
        input logic [31:0] s, input logic [31:0] m, input logic [4:0] n);
        logic [63:0] d;
        logic [31:0] r, mk, t;
        d = {s, s} >> n;
        r = d[31:0];
        mk = 32'hffff_ffff >> n;
        t = (k == 3) ? {32{s[31]}} : (k == 1) ? 32'h0 : m;
        return {|(r & ~mk) & s[31], (r & mk) | (t & ~mk), r};
    endfunction

    // one avalon transfer, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [3:0] a,
        input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        address <= a;
        writedata <= d;
        write <= wr;
        read <= !wr;
        do @(posedge clk); while (waitrequest !== 1'b0);
        q = readdata;
        write <= 1'b0;
        read <= 1'b0;
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // hang guard, the whole run needs well under 20000 cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            conclude();
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        logic [31:0] src, amt, aux, ins, q, pre;
        logic [64:0] e;
        logic [4:0]  n, ti;
        logic [3:0]  cr;
        logic        rec, cy, xso, c;
        int          k, w0;
        resetn = 1'b0;
        read = 1'b0;
        write = 1'b0;
        address = 4'h0;
        writedata = 32'h0;
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        void'($urandom(32'h3ed7));
        // all four kinds; counts 0 and 31 forced in every eighth pass
        for (int i = 0; i < 48; i++) begin
            k = i % 4;
            n = (i % 8 < 2) ? 5'(i % 8 * 31) : 5'($urandom);
            src = $urandom;
            amt = {27'($urandom), n};
            aux = $urandom;
            {rec, cy, xso} = 3'($urandom);
            ti = 5'($urandom);
            ins = {primary_opcode, 5'($urandom), ti,
                   (k == 1 || k == 2) ? n : 5'($urandom), xops[k], rec};
            bus(1'b1, addr_source, src, q);
            bus(1'b1, addr_amount, amt, q);
            bus(1'b1, addr_aux, aux, q);
            bus(1'b1, addr_flags, {26'h0, xso, cy, 4'h0}, q);
            bus(1'b0, addr_flags, 32'h0, pre);
            w0 = wr_cnt;
            bus(1'b1, addr_instr, ins, q);
            e = model(k, src, aux, n);
            c = (k == 3) ? e[64] : cy;
            cr = rec ? {e[63], !e[63] && |e[63:32], ~|e[63:32], xso} : pre[3:0];
            `CHK({cr0_field, shift_out_flag}, {cr, c})
            bus(1'b0, addr_result, 32'h0, q);
            `CHK(q, e[63:32])
            bus(1'b0, addr_aux, 32'h0, q);
            `CHK(q, e[31:0])
            bus(1'b0, addr_flags, 32'h0, q);
            `CHK({q[9:8], q[5:0]}, {2'b01, xso, c, cr})
            `CHK({last_idx, last_val}, {ti, e[63:32]})
            `CHK(wr_cnt - w0, 1)
        end
        // foreign primary opcode, then an unknown extended opcode
        for (int j = 0; j < 2; j++) begin
            w0 = wr_cnt;
            ins = j ? {primary_opcode, 15'h0, 10'h299, 1'b1} : 32'h7800_0000;
            bus(1'b1, addr_instr, ins, q);
            bus(1'b0, addr_flags, 32'h0, q);
            `CHK(q[9:8], 2'b10)
            bus(1'b0, addr_aux, 32'h0, q);
            `CHK(q, e[31:0])
            `CHK(wr_cnt - w0, 0)
        end
        bus(1'b0, 4'hf, 32'h0, q);
        `CHK(q, unmapped_rd)
        conclude();
    end
endmodule // mq_shift_right_unit_test
